//--- rtl/ppd_params.svh
// register offsets, index codes, field positions and reset values for the parallel port decode
`ifndef PPD_PARAMS_SVH
`define PPD_PARAMS_SVH

`define PPD_OFS_DATA 11'h000
`define PPD_OFS_STATUS 11'h001
`define PPD_OFS_CONTROL 11'h002
`define PPD_OFS_EPP_ADDR 11'h003
`define PPD_OFS_EPP_D0 11'h004
`define PPD_OFS_EPP_D3 11'h007
`define PPD_OFS_FIFO 11'h400
`define PPD_OFS_CFGB 11'h401
`define PPD_OFS_ECTL 11'h402
`define PPD_OFS_EIDX 11'h403
`define PPD_OFS_EDAT 11'h404
`define PPD_OFS_EAUX 11'h405

`define PPD_IDX_CTL0 3'h0
`define PPD_IDX_CTL2 3'h2
`define PPD_IDX_CTL4 3'h4
`define PPD_IDX_CFG0 3'h5

`define PPD_ECTL_MODE_MSB 7
`define PPD_ECTL_MODE_LSB 5
`define PPD_ECTL_RW_MASK 8'hFC
`define PPD_EIDX_OFS_MSB 2
`define PPD_CFG_EXT_EN_BIT 4
`define PPD_CFG0_CFGA_BIT 7
`define PPD_CFGA_BIT 3
`define PPD_EAUX_TAG_BIT 7

`define PPD_RST_BYTE 8'h00
`define PPD_RST_ECTL 8'h01
`define PPD_UNMAPPED_READ 8'hFF

`endif

//--- rtl/ppd_pkg.sv
// types for the parallel port register decode
package ppd_pkg;
  typedef enum logic [2:0] {
    PPD_MODE_SPP = 3'h0,
    PPD_MODE_PS2 = 3'h1,
    PPD_MODE_PPFIFO = 3'h2,
    PPD_MODE_ECP = 3'h3,
    PPD_MODE_EPP = 3'h4,
    PPD_MODE_RSVD = 3'h5,
    PPD_MODE_TEST = 3'h6,
    PPD_MODE_CONFIG = 3'h7
  } ppd_mode_t;

  typedef enum logic [3:0] {
    PPD_SEL_NONE, PPD_SEL_DATA, PPD_SEL_ECP_ADDRESS_FIFO, PPD_SEL_STATUS, PPD_SEL_CONTROL,
    PPD_SEL_EPP_ADDR, PPD_SEL_EPP_DATA, PPD_SEL_FIFO, PPD_SEL_CFGA, PPD_SEL_CFGB,
    PPD_SEL_ECTL, PPD_SEL_EIDX, PPD_SEL_EDAT, PPD_SEL_EAUX
  } ppd_sel_t;
endpackage

//--- rtl/ppd_index_regs.sv
// second-level indexed register bank behind the extended data window
`include "ppd_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ppd_index_regs (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [2:0] i_index,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_hit,
  output logic [7:0] o_ctl0,
  output logic [7:0] o_ctl2,
  output logic [7:0] o_ctl4,
  output logic [7:0] o_cfg0
);
  import ppd_pkg::*;

  logic [7:0] bank_reg [0:3];
  logic [1:0] slot;

  // ****************************************
  // index to slot map
  // ****************************************
  always_comb begin
    o_hit = 1'b1;
    slot = 2'd0;
    case (i_index)
      `PPD_IDX_CTL0: slot = 2'd0;
      `PPD_IDX_CTL2: slot = 2'd1;
      `PPD_IDX_CTL4: slot = 2'd2;
      `PPD_IDX_CFG0: slot = 2'd3;
      default: o_hit = 1'b0;
    endcase
  end

  // window writes land in selected slot
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int k = 0; k < 4; k++) begin
        bank_reg[k] <= `PPD_RST_BYTE;
      end
    end else if (i_wr && o_hit) begin
      bank_reg[slot] <= i_wdata;
    end
  end

  // holes in the index space read as zero
  assign o_rdata = o_hit ? bank_reg[slot] : `PPD_RST_BYTE;
  assign o_ctl0 = bank_reg[0];
  assign o_ctl2 = bank_reg[1];
  assign o_ctl4 = bank_reg[2];
  assign o_cfg0 = bank_reg[3];
endmodule
`default_nettype wire

//--- rtl/ppd_regs.sv
// parallel port runtime register decode, mode steered
// ****************************************
// Notes on behaviour
// - modes compatibility, bi-directional, FIFO, EPP, ECP, test and configuration are all decodable.
// - the mode field of the extended control register at 402h selects the mode.
// - the mode picks which register answers and which address bits form the base compare.
// - 18 first-level registers share 14 offsets, split by mode and direction.
// - offsets 403h to 405h work only in modes 0 to 3 with config bit 4 set.
// - four extended registers are reached only through a second-level index.
// - EPP and indexed registers decode only with an 8-byte aligned base.
// - index, data window and aux status need config bit 4 set.
// - in EPP mode offset 03h is an eight-bit read/write target select.
// - in EPP mode offsets 04h to 07h are four read/write data ports.
// - the extended index holds the second-level offset in its low bits, upper bits reserved.
// ****************************************
`include "ppd_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ppd_regs (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [15:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [15:0] i_base,
  input wire logic [7:0] i_port_cfg,
  input wire logic [7:0] i_pin_status,
  input wire logic [7:0] i_cfg_b,
  input wire logic i_fifo_full,
  input wire logic i_fifo_empty,
  input wire logic i_fifo_tag,
  input wire logic [7:0] i_fifo_rdata,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic [7:0] o_data_out,
  output logic [7:0] o_control,
  output logic [7:0] o_epp_addr,
  output logic o_epp_strobe,
  output logic o_epp_write,
  output logic [1:0] o_epp_port,
  output logic [7:0] o_epp_wdata,
  output logic o_fifo_push,
  output logic o_fifo_is_addr,
  output logic [7:0] o_fifo_wdata,
  output logic o_fifo_pop,
  output ppd_pkg::ppd_mode_t o_mode,
  output logic [7:0] o_ctl0,
  output logic [7:0] o_ctl2,
  output logic [7:0] o_ctl4,
  output logic [7:0] o_cfg0
);
  import ppd_pkg::*;

  logic [7:0] data_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] epp_addr_reg;
  logic [7:0] ectl_reg;
  logic [7:0] eidx_reg;
  logic [1:0] ps_sync_reg;
  logic [1:0] pf_sync_reg;
  logic [7:0] st_meta_reg;
  logic [7:0] st_sync_reg;
  logic tag_meta_reg;
  logic tag_sync_reg;
  ppd_mode_t mode;
  ppd_sel_t sel;
  logic aligned8;
  logic base_hit;
  logic ext_ok;
  logic [10:0] ofs;
  logic [7:0] ix_rdata;
  logic ix_hit;
  logic ix_wr;
  logic rd_acc;
  logic wr_acc;
  logic [7:0] rd_next;

  // mode comes from the extended control field
  assign mode = ppd_mode_t'(ectl_reg[`PPD_ECTL_MODE_MSB:`PPD_ECTL_MODE_LSB]);

  // ****************************************
  // base address compare
  // ****************************************
  // indexed and EPP decode need an aligned base
  assign aligned8 = (i_base[2:0] == 3'h0);
  assign ext_ok = i_port_cfg[`PPD_CFG_EXT_EN_BIT];

  // EPP and the 400h group claim eight bytes when the base is aligned, others four
  function automatic logic base_match(input logic [15:0] a, input logic [15:0] b,
                                      input logic epp);
    logic [15:0] hi;
    hi = a & 16'hFBFF;
    if (epp) begin
      base_match = (hi[15:3] == b[15:3]);
    end else begin
      base_match = (hi[15:2] == b[15:2]);
    end
  endfunction

  assign base_hit = base_match(i_addr, i_base, ((mode == PPD_MODE_EPP) || i_addr[10]) && aligned8);
  assign ofs = {i_addr[10], 7'h00, i_addr[2:0]};

  // ****************************************
  // first-level decode
  // ****************************************
  // one offset, several registers split by mode and direction
  always_comb begin
    sel = PPD_SEL_NONE;
    if (!base_hit) begin
      sel = PPD_SEL_NONE;
    end else if (ofs == `PPD_OFS_DATA) begin
      if (mode == PPD_MODE_SPP || mode == PPD_MODE_PS2 || mode == PPD_MODE_EPP) begin
        sel = PPD_SEL_DATA;
      end else if (mode == PPD_MODE_ECP && i_wr) begin
        sel = PPD_SEL_ECP_ADDRESS_FIFO;
      end
    end else if (ofs == `PPD_OFS_STATUS) begin
      sel = PPD_SEL_STATUS;
    end else if (ofs == `PPD_OFS_CONTROL) begin
      sel = PPD_SEL_CONTROL;
    end else if (ofs == `PPD_OFS_EPP_ADDR) begin
      // target select only in EPP mode
      if (mode == PPD_MODE_EPP && aligned8) begin
        sel = PPD_SEL_EPP_ADDR;
      end
    end else if (ofs >= `PPD_OFS_EPP_D0 && ofs <= `PPD_OFS_EPP_D3) begin
      if (mode == PPD_MODE_EPP && aligned8) begin
        sel = PPD_SEL_EPP_DATA;
      end
    end else if (ofs == `PPD_OFS_FIFO) begin
      if (mode == PPD_MODE_PPFIFO && i_wr) begin
        sel = PPD_SEL_FIFO;
      end else if (mode == PPD_MODE_ECP || mode == PPD_MODE_TEST) begin
        sel = PPD_SEL_FIFO;
      end else if (mode == PPD_MODE_CONFIG && i_rd) begin
        sel = PPD_SEL_CFGA;
      end
    end else if (ofs == `PPD_OFS_CFGB) begin
      if (mode == PPD_MODE_CONFIG && i_rd) begin
        sel = PPD_SEL_CFGB;
      end
    end else if (ofs == `PPD_OFS_ECTL) begin
      sel = PPD_SEL_ECTL;
    end else if (ext_ok && aligned8 && mode <= PPD_MODE_ECP) begin
      // extended trio only in modes 0 to 3 with the extension on
      if (ofs == `PPD_OFS_EIDX) begin
        sel = PPD_SEL_EIDX;
      end else if (ofs == `PPD_OFS_EDAT) begin
        sel = PPD_SEL_EDAT;
      end else if (ofs == `PPD_OFS_EAUX) begin
        sel = PPD_SEL_EAUX;
      end
    end
  end

  assign rd_acc = i_rd && !i_wr;
  assign wr_acc = i_wr && !i_rd;
  // indexed bank reached only through the data window
  assign ix_wr = wr_acc && (sel == PPD_SEL_EDAT);

  ppd_index_regs u_index (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_index(eidx_reg[`PPD_EIDX_OFS_MSB:0]),
    .i_wr(ix_wr),
    .i_wdata(i_wdata),
    .o_rdata(ix_rdata),
    .o_hit(ix_hit),
    .o_ctl0(o_ctl0),
    .o_ctl2(o_ctl2),
    .o_ctl4(o_ctl4),
    .o_cfg0(o_cfg0)
  );

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_meta_reg <= `PPD_RST_BYTE;
      st_sync_reg <= `PPD_RST_BYTE;
      tag_meta_reg <= 1'b0;
      tag_sync_reg <= 1'b0;
    end else begin
      st_meta_reg <= i_pin_status;
      st_sync_reg <= st_meta_reg;
      tag_meta_reg <= i_fifo_tag;
      tag_sync_reg <= tag_meta_reg;
    end
  end

  // fifo flags come from core logic, two register stages ahead of the control register
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pf_sync_reg <= 2'b01;
      ps_sync_reg <= 2'b01;
    end else begin
      pf_sync_reg <= {i_fifo_full, i_fifo_empty};
      ps_sync_reg <= pf_sync_reg;
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  // mode written by software, flag bits are read-only
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ectl_reg <= `PPD_RST_ECTL;
    end else if (wr_acc && sel == PPD_SEL_ECTL) begin
      ectl_reg <= (i_wdata & `PPD_ECTL_RW_MASK) | {6'h00, ps_sync_reg};
    end else begin
      ectl_reg <= {ectl_reg[7:2], ps_sync_reg};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      data_reg <= `PPD_RST_BYTE;
      ctrl_reg <= `PPD_RST_BYTE;
    end else begin
      if (wr_acc && sel == PPD_SEL_DATA) begin
        data_reg <= i_wdata;
      end
      if (wr_acc && sel == PPD_SEL_CONTROL) begin
        ctrl_reg <= i_wdata;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      epp_addr_reg <= `PPD_RST_BYTE;
    end else if (wr_acc && sel == PPD_SEL_EPP_ADDR) begin
      epp_addr_reg <= i_wdata;
    end
  end

  // upper bits reserved, kept at zero
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      eidx_reg <= `PPD_RST_BYTE;
    end else if (wr_acc && sel == PPD_SEL_EIDX) begin
      eidx_reg <= {5'h00, i_wdata[`PPD_EIDX_OFS_MSB:0]};
    end
  end

  // ****************************************
  // EPP port and fifo strobes
  // ****************************************
  // data port access strobe with port number
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_epp_strobe <= 1'b0;
      o_epp_write <= 1'b0;
      o_epp_port <= 2'b00;
      o_epp_wdata <= `PPD_RST_BYTE;
    end else begin
      o_epp_strobe <= (rd_acc || wr_acc) && sel == PPD_SEL_EPP_DATA;
      if ((rd_acc || wr_acc) && sel == PPD_SEL_EPP_DATA) begin
        o_epp_write <= wr_acc;
        o_epp_port <= i_addr[1:0];
        o_epp_wdata <= i_wdata;
      end
    end
  end

  // ecp address and data fifos share one push path
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_fifo_push <= 1'b0;
      o_fifo_is_addr <= 1'b0;
      o_fifo_wdata <= `PPD_RST_BYTE;
      o_fifo_pop <= 1'b0;
    end else begin
      o_fifo_push <= wr_acc && (sel == PPD_SEL_FIFO || sel == PPD_SEL_ECP_ADDRESS_FIFO);
      o_fifo_pop <= rd_acc && sel == PPD_SEL_FIFO;
      if (wr_acc && (sel == PPD_SEL_FIFO || sel == PPD_SEL_ECP_ADDRESS_FIFO)) begin
        o_fifo_is_addr <= (sel == PPD_SEL_ECP_ADDRESS_FIFO);
        o_fifo_wdata <= i_wdata;
      end
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    rd_next = `PPD_UNMAPPED_READ;
    case (sel)
      PPD_SEL_DATA: rd_next = data_reg;
      PPD_SEL_STATUS: rd_next = st_sync_reg;
      PPD_SEL_CONTROL: rd_next = ctrl_reg;
      PPD_SEL_EPP_ADDR: rd_next = epp_addr_reg;
      PPD_SEL_EPP_DATA: rd_next = i_fifo_rdata;
      PPD_SEL_FIFO: rd_next = i_fifo_rdata;
      PPD_SEL_CFGA: rd_next = {4'h0, o_cfg0[`PPD_CFG0_CFGA_BIT], 3'h0};
      PPD_SEL_CFGB: rd_next = i_cfg_b;
      PPD_SEL_ECTL: rd_next = ectl_reg;
      PPD_SEL_EIDX: rd_next = eidx_reg;
      // window read returns the indexed register
      PPD_SEL_EDAT: rd_next = ix_hit ? ix_rdata : `PPD_RST_BYTE;
      PPD_SEL_EAUX: rd_next = {tag_sync_reg, 7'h00};
      default: rd_next = `PPD_UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= `PPD_RST_BYTE;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= rd_acc && base_hit;
      if (rd_acc) begin
        o_rdata <= rd_next;
      end
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_data_out <= `PPD_RST_BYTE;
      o_control <= `PPD_RST_BYTE;
      o_epp_addr <= `PPD_RST_BYTE;
      o_mode <= PPD_MODE_SPP;
    end else begin
      o_data_out <= data_reg;
      o_control <= ctrl_reg;
      o_epp_addr <= epp_addr_reg;
      o_mode <= mode;
    end
  end
endmodule
`default_nettype wire

//--- verification/ppd_regs_props.sv
// assertion checker for the parallel port register decode
`timescale 1ns/1ps
`default_nettype none
module ppd_regs_props (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [15:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [15:0] i_base,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic [7:0] o_epp_addr,
  input wire logic o_epp_strobe,
  input wire logic o_epp_write,
  input wire logic [1:0] o_epp_port,
  input wire logic [7:0] o_epp_wdata,
  input wire logic o_fifo_push,
  input wire logic [7:0] o_fifo_wdata,
  input wire logic o_fifo_pop,
  input wire logic [2:0] o_mode,
  input wire logic [7:0] o_ctl0,
  input wire logic [7:0] o_ctl2,
  input wire logic [7:0] o_ctl4,
  input wire logic [7:0] o_cfg0
);
  import ppd_pkg::*;
  logic [2:0] w_mode;
  logic [1:0] a_lo;
  logic a_b2;
  assign w_mode = i_wdata[7:5];
  assign a_lo = i_addr[1:0];
  assign a_b2 = i_addr[2];
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // ****************
  // decode relations
  // ****************
  sequence s_ectl_write;
    i_wr && !i_rd && i_addr == i_base + 16'h0402;
  endsequence
  a_mode_from_ectl: assert property (s_ectl_write |-> ##2 o_mode == $past(w_mode, 2))
    else $error("mode not taken from control write");
  a_mode_needs_write: assert property ($changed(o_mode) |-> $past(i_wr, 2))
    else $error("mode changed without write");
  a_rvalid_needs_read: assert property (o_rvalid |-> $past(i_rd && !i_wr))
    else $error("read valid without read");
  a_rdata_hold: assert property (!i_rd |=> $stable(o_rdata))
    else $error("read data moved without read");
  a_epp_strobe_cause: assert property (o_epp_strobe |-> $past(i_rd ^ i_wr) && $past(a_b2))
    else $error("data port strobe without access");
  a_epp_port_num: assert property (o_epp_strobe |-> o_epp_port == $past(a_lo))
    else $error("data port number wrong");
  a_epp_wr_data: assert property (o_epp_strobe && o_epp_write |-> o_epp_wdata == $past(i_wdata))
    else $error("data port write data wrong");
  a_target_hold: assert property (!$past(i_wr) |=> $stable(o_epp_addr))
    else $error("target select moved without write");
  a_index_hold: assert property (!i_wr |=> $stable({o_ctl0, o_ctl2, o_ctl4, o_cfg0}))
    else $error("indexed register moved without write");
  a_push_cause: assert property (o_fifo_push |-> $past(i_wr) && o_fifo_wdata == $past(i_wdata))
    else $error("fifo push without write");
  a_pop_cause: assert property (o_fifo_pop |-> $past(i_rd))
    else $error("fifo pop without read");
endmodule
`default_nettype wire

//--- verification/ppd_printer_model.sv
// cable-side peripheral model for the port decode bench
`timescale 1ns/1ps
`default_nettype none
module ppd_printer_model (
  input wire logic i_core_clk,
  input wire logic i_strobe,
  input wire logic i_write,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_status,
  output logic [7:0] o_rdata,
  output logic o_tag
);
  initial begin
    o_status = 8'h5A;
    o_rdata = 8'hC3;
    o_tag = 1'b1;
  end
  // answer changes per write transfer
  // a fresh value each write so a stale read cannot pass
  always @(posedge i_core_clk) begin
    if (i_strobe && i_write) begin
      o_rdata <= ~i_wdata;
    end
  end
endmodule
`default_nettype wire

//--- verification/ppd_regs_bench.sv
// bench for the parallel port register decode
`timescale 1ns/1ps
`default_nettype none
module ppd_regs_bench;
  import ppd_pkg::*;
  logic i_core_clk = 1'b0, i_rstn = 1'b0, i_rd = 1'b0, i_wr = 1'b0;
  logic i_fifo_full = 1'b0, i_fifo_empty = 1'b1, i_fifo_tag;
  logic [15:0] i_addr = 16'h0000, i_base = 16'h0378;
  logic [7:0] i_wdata = 8'h00, i_port_cfg = 8'h10, i_cfg_b = 8'h2C, i_pin_status;
  logic [7:0] i_fifo_rdata, o_rdata, o_data_out, o_control, o_epp_addr, o_epp_wdata;
  logic [7:0] o_fifo_wdata, o_ctl0, o_ctl2, o_ctl4, o_cfg0;
  logic o_rvalid, o_epp_strobe, o_epp_write, o_fifo_push, o_fifo_is_addr, o_fifo_pop;
  logic [1:0] o_epp_port;
  ppd_mode_t o_mode;
  logic [7:0] idx [4] = '{8'h00, 8'h02, 8'h04, 8'h05};
  logic [7:0] val [4] = '{8'h11, 8'h22, 8'h44, 8'hAA};
  int err_count = 0, checks = 0;
  ppd_regs u_ppd_regs (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata), .i_base(i_base), .i_port_cfg(i_port_cfg),
    .i_pin_status(i_pin_status), .i_cfg_b(i_cfg_b), .i_fifo_full(i_fifo_full),
    .i_fifo_empty(i_fifo_empty), .i_fifo_tag(i_fifo_tag), .i_fifo_rdata(i_fifo_rdata),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_data_out(o_data_out),
    .o_control(o_control), .o_epp_addr(o_epp_addr), .o_epp_strobe(o_epp_strobe),
    .o_epp_write(o_epp_write), .o_epp_port(o_epp_port), .o_epp_wdata(o_epp_wdata),
    .o_fifo_push(o_fifo_push), .o_fifo_is_addr(o_fifo_is_addr),
    .o_fifo_wdata(o_fifo_wdata), .o_fifo_pop(o_fifo_pop), .o_mode(o_mode),
    .o_ctl0(o_ctl0), .o_ctl2(o_ctl2), .o_ctl4(o_ctl4), .o_cfg0(o_cfg0));
  ppd_printer_model u_ppd_printer_model (.i_core_clk(i_core_clk), .i_strobe(o_epp_strobe),
    .i_write(o_epp_write), .i_wdata(o_epp_wdata), .o_status(i_pin_status),
    .o_rdata(i_fifo_rdata), .o_tag(i_fifo_tag));
  always #2.5 i_core_clk = ~i_core_clk;
  // ****************
  // access tasks
  // ****************
  task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] ofs, input logic [7:0] d);
    @(negedge i_core_clk);
    i_addr = i_base + ofs;
    i_wdata = d;
    i_wr = 1'b1;
    @(negedge i_core_clk);
    i_wr = 1'b0;
  endtask
  task automatic rdc(input logic [15:0] ofs, input logic [7:0] exp);
    @(negedge i_core_clk);
    i_addr = i_base + ofs;
    i_rd = 1'b1;
    @(negedge i_core_clk);
    i_rd = 1'b0;
    cmp(o_rdata, exp);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ****************
  // tests
  // ****************
  initial begin
    repeat (3) @(negedge i_core_clk);
    i_rstn = 1'b1;
    rdc(16'h0402, 8'h01);
    i_fifo_full = 1'b1;
    i_fifo_empty = 1'b0;
    wr(16'h0402, 8'h1F);
    repeat (2) @(negedge i_core_clk);
    rdc(16'h0402, 8'h1E);
    i_fifo_full = 1'b0;
    i_fifo_empty = 1'b1;
    $display("control register test done");
    // every mode code, checking which register answers
    for (int m = 0; m < 8; m++) begin
      wr(16'h0402, {m[2:0], 5'h00});
      @(negedge i_core_clk);
      cmp({5'h00, o_mode}, m[7:0]);
      wr(16'h0003, 8'h30 + m[7:0]);
      rdc(16'h0003, m == 4 ? 8'h34 : 8'hFF);
      rdc(16'h0403, m < 4 ? 8'h00 : 8'hFF);
    end
    cmp(o_epp_addr, 8'h34);
    $display("mode table test done");
    wr(16'h0402, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(16'h0403, idx[k]);
      wr(16'h0404, val[k]);
      rdc(16'h0404, val[k]);
    end
    cmp(o_ctl0, 8'h11);
    cmp(o_ctl2, 8'h22);
    cmp(o_ctl4, 8'h44);
    cmp(o_cfg0, 8'hAA);
    wr(16'h0403, 8'h01);
    rdc(16'h0404, 8'h00);
    wr(16'h0403, 8'hF5);
    rdc(16'h0404, 8'hAA);
    rdc(16'h0403, 8'h05);
    i_port_cfg = 8'h00;
    rdc(16'h0403, 8'hFF);
    rdc(16'h0404, 8'hFF);
    i_port_cfg = 8'h10;
    $display("indexed register test done");
    wr(16'h0402, 8'h80);
    wr(16'h0005, 8'h5A);
    cmp({7'h00, o_epp_strobe}, 8'h01);
    cmp({5'h00, o_epp_write, o_epp_port}, 8'h05);
    cmp(o_epp_wdata, 8'h5A);
    rdc(16'h0006, 8'hA5);
    cmp({5'h00, o_epp_write, o_epp_port}, 8'h02);
    i_base = 16'h037C;
    rdc(16'h0003, 8'hFF);
    i_base = 16'h0378;
    $display("data port test done");
    wr(16'h0402, 8'h60);
    wr(16'h0000, 8'h77);
    cmp({o_fifo_push, o_fifo_is_addr, 6'h00}, 8'hC0);
    cmp(o_fifo_wdata, 8'h77);
    wr(16'h0400, 8'h88);
    cmp({o_fifo_push, o_fifo_is_addr, 6'h00}, 8'h80);
    rdc(16'h0400, 8'hA5);
    wr(16'h0402, 8'h00);
    wr(16'h0000, 8'h3E);
    rdc(16'h0000, 8'h3E);
    cmp(o_data_out, 8'h3E);
    $display("fifo and data test done");
    wr(16'h0002, 8'h2B);
    rdc(16'h0002, 8'h2B);
    cmp(o_control, 8'h2B);
    rdc(16'h0001, 8'h5A);
    cmp({7'h00, o_rvalid}, 8'h01);
    rdc(16'h0405, 8'h80);
    wr(16'h0402, 8'h40);
    wr(16'h0400, 8'h99);
    cmp({o_fifo_push, o_fifo_is_addr, 6'h00}, 8'h80);
    rdc(16'h0400, 8'hFF);
    wr(16'h0402, 8'hC0);
    rdc(16'h0400, 8'hA5);
    cmp({7'h00, o_fifo_pop}, 8'h01);
    wr(16'h0402, 8'hE0);
    rdc(16'h0400, 8'h08);
    rdc(16'h0401, 8'h2C);
    $display("status and config test done");
    @(negedge i_core_clk);
    i_rstn = 1'b0;
    repeat (3) @(negedge i_core_clk);
    i_rstn = 1'b1;
    rdc(16'h0402, 8'h01);
    cmp({5'h00, o_mode}, 8'h00);
    rdc(16'h0403, 8'h00);
    cmp(o_cfg0, 8'h00);
    $display("mid-run reset test done");
    give_verdict();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge i_core_clk);
    err_count++;
    give_verdict();
  end
endmodule
bind ppd_regs ppd_regs_props u_ppd_regs_props (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
  .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata), .i_base(i_base),
  .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_epp_addr(o_epp_addr),
  .o_epp_strobe(o_epp_strobe), .o_epp_write(o_epp_write), .o_epp_port(o_epp_port),
  .o_epp_wdata(o_epp_wdata), .o_fifo_push(o_fifo_push), .o_fifo_wdata(o_fifo_wdata),
  .o_fifo_pop(o_fifo_pop), .o_mode(o_mode), .o_ctl0(o_ctl0), .o_ctl2(o_ctl2),
  .o_ctl4(o_ctl4), .o_cfg0(o_cfg0));
`default_nettype wire
